// ---- logic/pcs_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the stager.
// Assumes: Avalon-MM word addresses are byte address divided by four.
// Notes: Definitions only.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_CLK_HZ 200000000
`define PCS_TICK_MS 1
`define PCS_TICK_CYC (`PCS_CLK_HZ / 1000 * `PCS_TICK_MS)
`define PCS_MS_PER_SEC 10'h3E7
`define PCS_SEC_PER_HOUR 12'hE0F
`define PCS_ADR_CTRL 5'h00
`define PCS_ADR_ACT_THR 5'h01
`define PCS_ADR_OVR_THR 5'h02
`define PCS_ADR_STG_DLY 5'h03
`define PCS_ADR_DSTG_DLY 5'h04
`define PCS_ADR_ILK 5'h05
`define PCS_ADR_SPEED 5'h06
`define PCS_ADR_STATUS 5'h07
`define PCS_ADR_ON_DLY 5'h08
`define PCS_ADR_ACT_HOLD 5'h09
`define PCS_ADR_OFF_DLY 5'h0A
`define PCS_ADR_DEACT_HOLD 5'h0B
`define PCS_ADR_MAX_CONT 5'h0C
`define PCS_ADR_ABS_LIM 5'h0D
`define PCS_ADR_HRS0 5'h0E
`define PCS_CTRL_CFG_LO 0
`define PCS_CTRL_SEL_LO 4
`define PCS_CTRL_SW_EN 6
`define PCS_CTRL_EN_SRC 7
`define PCS_CTRL_TECH_EN 8
`define PCS_CTRL_TECH_MODE 9
`define PCS_CTRL_OFF_ORDER 10
`define PCS_RST_CTRL 11'h000
`define PCS_RST_THR 16'h0100
`define PCS_RST_OVR 16'h0400
`define PCS_RST_TIME 16'h0000
`define PCS_RST_SPEED 16'h4000
`endif

// ---- logic/pcs_pkg.sv ----
// Purpose: Types shared by the stager.
// Assumes: Three external motors.
// Notes: State is one packed struct registered in one process.
`default_nettype none
package pcs_pkg;
	typedef enum logic [2:0] {PCS_IDLE, PCS_WAIT, PCS_SWDLY, PCS_RAMP, PCS_HOLD} pcs_state_t;
	typedef struct packed {
		pcs_state_t st;
		logic [2:0] lvl;
		logic [2:0] mask;
		logic [2:0] pend;
		logic up;
		logic [17:0] tick;
		logic [9:0] ms;
		logic [15:0] tmr;
		logic [15:0] ilk;
		logic [2:0][11:0] sub;
		logic [2:0][15:0] hrs;
		logic [2:0][15:0] cont;
		logic [10:0] ctrl;
		logic [15:0] act_thr;
		logic [15:0] ovr_thr;
		logic [15:0] stg_dly;
		logic [15:0] dstg_dly;
		logic [15:0] ilk_time;
		logic [15:0] speed;
		logic [15:0] on_dly;
		logic [15:0] act_hold;
		logic [15:0] off_dly;
		logic [15:0] deact_hold;
		logic [15:0] max_cont;
		logic [15:0] abs_lim;
		logic ack;
		logic [31:0] rdata;
		logic en_s1;
		logic en_s2;
		logic off_s1;
		logic off_s2;
		logic spd_hold;
		logic tech_hold;
	} pcs_reg_t;
endpackage
`default_nettype wire

// ---- logic/pcs_stager.sv ----
// Purpose: Cascade stager that switches three fixed-speed motors beside a main drive.
// Assumes: Deviation and drive flags come from logic on clk_sys; pins are asynchronous.
// Notes: All times are in milliseconds, run time in hours.
// What this block does
// R1: Config 0 disables; 1 is motor one.
// R2: Config 2 and 3 two-motor stage lists.
// R3: Configs 4 to 8 three-motor stage lists.
// R4: Removal walks the same list backwards.
// R5: Selection mode: stage order or run hours.
// R6: Status bits 0 to 2 drive outputs.
// R7: Runs only with controller enabled, setpoint mode.
// R8: After switching, main drive goes to switch speed.
// R9: Activation hold time after switching on.
// R10: Deactivation hold time after switching off.
// R11: Configurable destage order on OFF command.
// R12: Motor-on delay before switching on.
// R13: Motor-off delay before switching off.
// R14: Separate destaging delay before removal.
// R15: Count hours; enforce continuous and absolute limits in run-hours selection only.
// R16: Selectable enable source switches staging.
// R17: Over overcontrol threshold, switch immediately.
// R18: Between thresholds, run staging delay first.
// R19: Controller disabled while ramping to switch speed.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`include "pcs_cfg.svh"
`default_nettype none
module pcs_stager import pcs_pkg::*; #(
	parameter int TICK_CYC = `PCS_TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic signed [15:0] pid_deviation,
	input wire logic main_at_max,
	input wire logic main_at_min,
	input wire logic main_at_switch_speed,
	input wire logic staging_enable_pin,
	input wire logic off_command_pin,
	output logic [2:0] digital_out,
	output logic speed_hold,
	output logic [15:0] speed_target,
	output logic tech_ctrl_hold
);
	// Stage list entry for a configuration; level 0 is no motor.
	function automatic logic [2:0] stage_mask(input logic [3:0] cfg, input logic [2:0] lvl);
		logic [2:0] m;
		m = 3'h0;
		if (lvl != 3'h0) begin
			m = 3'h1;
		end
		case (cfg)
			4'h2: if (lvl == 3'h2) m = 3'h3;
			4'h3: case (lvl)
				3'h2: m = 3'h2;
				3'h3: m = 3'h3;
				default: ;
			endcase
			4'h4: case (lvl)
				3'h2: m = 3'h3;
				3'h3: m = 3'h7;
				default: ;
			endcase
			4'h5: case (lvl)
				3'h2: m = 3'h4;
				3'h3: m = 3'h5;
				3'h4: m = 3'h7;
				default: ;
			endcase
			4'h6: case (lvl)
				3'h2: m = 3'h2;
				3'h3: m = 3'h3;
				3'h4: m = 3'h6;
				3'h5: m = 3'h7;
				default: ;
			endcase
			4'h7: case (lvl)
				3'h2: m = 3'h3;
				3'h3: m = 3'h4;
				3'h4: m = 3'h5;
				3'h5: m = 3'h7;
				default: ;
			endcase
			4'h8: case (lvl)
				3'h2: m = 3'h2;
				3'h3: m = 3'h4;
				3'h4: m = 3'h5;
				3'h5: m = 3'h6;
				3'h6: m = 3'h7;
				default: ;
			endcase
			default: ;
		endcase
		return m;
	endfunction

	// Number of levels in a stage list, and motors it uses.
	function automatic logic [2:0] max_level(input logic [3:0] cfg, input logic by_hours);
		logic [2:0] n;
		case (cfg)
			4'h1: n = 3'h1;
			4'h2: n = 3'h2;
			4'h3: n = by_hours ? 3'h2 : 3'h3;
			4'h4: n = 3'h3;
			4'h5: n = by_hours ? 3'h3 : 3'h4;
			4'h6, 4'h7: n = by_hours ? 3'h3 : 3'h5;
			4'h8: n = by_hours ? 3'h3 : 3'h6;
			default: n = 3'h0;
		endcase
		return n;
	endfunction

	pcs_reg_t s, n;
	logic [3:0] cfg;
	logic by_hours, en_src, active, tick, sec, ilk_done, off_req;
	logic add_cond, rem_cond, add_fast, rem_fast, tmr_zero;
	logic [2:0] maxl, avail, expired, pick_add, pick_rem, add_mask, rem_mask;
	logic [15:0] best;
	logic req, wr_now, rd_now;

	assign cfg = s.ctrl[`PCS_CTRL_CFG_LO +: 4];
	assign by_hours = s.ctrl[`PCS_CTRL_SEL_LO +: 2] != 2'h0; // R5
	assign en_src = s.ctrl[`PCS_CTRL_EN_SRC] ? s.en_s2 : s.ctrl[`PCS_CTRL_SW_EN]; // R16
	assign active = (cfg != 4'h0) && (cfg <= 4'h8) && en_src && s.ctrl[`PCS_CTRL_TECH_EN]
		&& !s.ctrl[`PCS_CTRL_TECH_MODE]; // R1 R7
	assign off_req = (!active || s.off_s2) && (s.mask != 3'h0);
	assign maxl = max_level(cfg, by_hours);
	assign tick = s.tick == 18'(TICK_CYC - 1);
	assign sec = tick && (s.ms == `PCS_MS_PER_SEC);
	assign ilk_done = s.ilk == 16'h0000;
	assign tmr_zero = s.tmr == 16'h0000;
	assign add_cond = (pid_deviation > $signed({1'b0, s.act_thr[14:0]})) && main_at_max;
	assign rem_cond = (pid_deviation < -$signed({1'b0, s.act_thr[14:0]})) && main_at_min;
	assign add_fast = pid_deviation > $signed({1'b0, s.ovr_thr[14:0]});
	assign rem_fast = pid_deviation < -$signed({1'b0, s.ovr_thr[14:0]});
	assign req = avs_read || avs_write;
	assign wr_now = avs_write && s.ack;
	assign rd_now = avs_read && !s.ack;

	// Motors past a run-time limit may not be added and are forced off in hours mode.
	always_comb begin
		avail = 3'h0;
		expired = 3'h0;
		pick_add = 3'h0;
		pick_rem = 3'h0;
		best = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			if ((s.abs_lim != 16'h0000 && s.hrs[i] >= s.abs_lim)
				|| (s.max_cont != 16'h0000 && s.cont[i] >= s.max_cont)) begin // R15
				expired[i] = s.mask[i];
			end else begin
				avail[i] = !s.mask[i];
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (avail[i] && (pick_add == 3'h0 || s.hrs[i] < best)) begin
				pick_add = 3'(1 << i);
				best = s.hrs[i];
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (s.mask[i] && (pick_rem == 3'h0 || s.hrs[i] > best)) begin
				pick_rem = 3'(1 << i);
				best = s.hrs[i];
			end
		end
		if (expired != 3'h0) begin
			pick_rem = expired & -expired;
		end
		add_mask = by_hours ? (s.mask | pick_add) : stage_mask(cfg, s.lvl + 3'h1);
		rem_mask = by_hours ? (s.mask & ~pick_rem) : stage_mask(cfg, s.lvl - 3'h1); // R4
	end

	always_comb begin
		n = s;
		n.en_s1 = staging_enable_pin;
		n.en_s2 = s.en_s1;
		n.off_s1 = off_command_pin;
		n.off_s2 = s.off_s1;
		n.tick = tick ? 18'h00000 : s.tick + 18'h00001;
		if (tick) begin
			n.ms = (s.ms == `PCS_MS_PER_SEC) ? 10'h000 : s.ms + 10'h001;
			if (!tmr_zero) begin
				n.tmr = s.tmr - 16'h0001;
			end
			if (!ilk_done) begin
				n.ilk = s.ilk - 16'h0001;
			end
		end
		// Hour counting runs only for motors whose contactor is closed.
		for (int i = 0; i < 3; i++) begin
			if (sec && s.mask[i]) begin
				n.sub[i] = (s.sub[i] == `PCS_SEC_PER_HOUR) ? 12'h000 : s.sub[i] + 12'h001;
				if (s.sub[i] == `PCS_SEC_PER_HOUR) begin
					n.hrs[i] = s.hrs[i] + 16'h0001; // R15
					n.cont[i] = s.cont[i] + 16'h0001;
				end
			end
			if (!s.mask[i]) begin
				n.cont[i] = 16'h0000;
			end
		end

		case (s.st)
			PCS_IDLE: begin
				if (off_req) begin
					n.up = 1'b0;
					n.pend = s.ctrl[`PCS_CTRL_OFF_ORDER] ? 3'h0 : rem_mask; // R11
					n.tmr = s.off_dly; // R13
					n.st = PCS_SWDLY;
				end else if (active && by_hours && expired != 3'h0 && ilk_done) begin
					n.up = 1'b0;
					n.pend = rem_mask;
					n.tmr = s.off_dly;
					n.st = PCS_SWDLY;
				end else if (active && ilk_done && add_cond && s.lvl < maxl
					&& add_mask != s.mask) begin
					n.up = 1'b1;
					n.pend = add_mask; // R2 R3
					n.tmr = add_fast ? s.on_dly : s.stg_dly; // R17 R18
					n.st = add_fast ? PCS_SWDLY : PCS_WAIT;
				end else if (active && ilk_done && rem_cond && s.lvl != 3'h0) begin
					n.up = 1'b0;
					n.pend = rem_mask;
					n.tmr = rem_fast ? s.off_dly : s.dstg_dly; // R14 R17
					n.st = rem_fast ? PCS_SWDLY : PCS_WAIT;
				end
			end
			PCS_WAIT: begin
				// Abandon the wait if the demand disappears before the delay runs out.
				if (off_req || (s.up ? !add_cond : !rem_cond)) begin
					n.st = PCS_IDLE;
				end else if (tmr_zero) begin // R18
					n.tmr = s.up ? s.on_dly : s.off_dly; // R12 R13
					n.st = PCS_SWDLY;
				end
			end
			PCS_SWDLY: begin
				if (tmr_zero) begin
					n.mask = s.pend; // R6
					n.lvl = s.up ? s.lvl + 3'h1 : (s.pend == 3'h0 ? 3'h0 : s.lvl - 3'h1);
					n.ilk = s.ilk_time;
					n.st = PCS_RAMP; // R8
				end
			end
			PCS_RAMP: begin
				if (main_at_switch_speed) begin
					n.tmr = s.up ? s.act_hold : s.deact_hold; // R9 R10
					n.st = PCS_HOLD;
				end
			end
			PCS_HOLD: begin
				if (tmr_zero) begin
					n.st = PCS_IDLE;
				end
			end
			default: n.st = PCS_IDLE;
		endcase
		n.spd_hold = (n.st == PCS_RAMP) || (n.st == PCS_HOLD); // R8 R9 R10
		n.tech_hold = n.st == PCS_RAMP; // R19

		// A request is answered on the second edge; writes land on that edge.
		n.ack = req && !s.ack;
		if (rd_now) begin
			n.rdata = 32'h00000000;
			case (avs_address)
				`PCS_ADR_CTRL: n.rdata = 32'(s.ctrl);
				`PCS_ADR_ACT_THR: n.rdata = 32'(s.act_thr);
				`PCS_ADR_OVR_THR: n.rdata = 32'(s.ovr_thr);
				`PCS_ADR_STG_DLY: n.rdata = 32'(s.stg_dly);
				`PCS_ADR_DSTG_DLY: n.rdata = 32'(s.dstg_dly);
				`PCS_ADR_ILK: n.rdata = 32'(s.ilk_time);
				`PCS_ADR_SPEED: n.rdata = 32'(s.speed);
				`PCS_ADR_STATUS: n.rdata = {22'h0, active, s.st, s.lvl, s.mask};
				`PCS_ADR_ON_DLY: n.rdata = 32'(s.on_dly);
				`PCS_ADR_ACT_HOLD: n.rdata = 32'(s.act_hold);
				`PCS_ADR_OFF_DLY: n.rdata = 32'(s.off_dly);
				`PCS_ADR_DEACT_HOLD: n.rdata = 32'(s.deact_hold);
				`PCS_ADR_MAX_CONT: n.rdata = 32'(s.max_cont);
				`PCS_ADR_ABS_LIM: n.rdata = 32'(s.abs_lim);
				`PCS_ADR_HRS0: n.rdata = 32'(s.hrs[0]);
				`PCS_ADR_HRS0 + 5'h01: n.rdata = 32'(s.hrs[1]);
				`PCS_ADR_HRS0 + 5'h02: n.rdata = 32'(s.hrs[2]);
				default: n.rdata = 32'h00000000;
			endcase
		end
		// Only byte lanes 0 and 1 hold data; a write without both lanes enabled is ignored.
		if (wr_now && avs_byteenable[1:0] == 2'h3) begin
			case (avs_address)
				`PCS_ADR_CTRL: n.ctrl = avs_writedata[10:0];
				`PCS_ADR_ACT_THR: n.act_thr = avs_writedata[15:0];
				`PCS_ADR_OVR_THR: n.ovr_thr = avs_writedata[15:0];
				`PCS_ADR_STG_DLY: n.stg_dly = avs_writedata[15:0];
				`PCS_ADR_DSTG_DLY: n.dstg_dly = avs_writedata[15:0];
				`PCS_ADR_ILK: n.ilk_time = avs_writedata[15:0];
				`PCS_ADR_SPEED: n.speed = avs_writedata[15:0];
				`PCS_ADR_ON_DLY: n.on_dly = avs_writedata[15:0];
				`PCS_ADR_ACT_HOLD: n.act_hold = avs_writedata[15:0];
				`PCS_ADR_OFF_DLY: n.off_dly = avs_writedata[15:0];
				`PCS_ADR_DEACT_HOLD: n.deact_hold = avs_writedata[15:0];
				`PCS_ADR_MAX_CONT: n.max_cont = avs_writedata[15:0];
				`PCS_ADR_ABS_LIM: n.abs_lim = avs_writedata[15:0];
				`PCS_ADR_HRS0: n.hrs[0] = avs_writedata[15:0];
				`PCS_ADR_HRS0 + 5'h01: n.hrs[1] = avs_writedata[15:0];
				`PCS_ADR_HRS0 + 5'h02: n.hrs[2] = avs_writedata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= PCS_IDLE;
			s.ctrl <= `PCS_RST_CTRL;
			s.act_thr <= `PCS_RST_THR;
			s.ovr_thr <= `PCS_RST_OVR;
			s.stg_dly <= `PCS_RST_TIME;
			s.dstg_dly <= `PCS_RST_TIME;
			s.ilk_time <= `PCS_RST_TIME;
			s.speed <= `PCS_RST_SPEED;
			s.on_dly <= `PCS_RST_TIME;
			s.act_hold <= `PCS_RST_TIME;
			s.off_dly <= `PCS_RST_TIME;
			s.deact_hold <= `PCS_RST_TIME;
			s.max_cont <= `PCS_RST_TIME;
			s.abs_lim <= `PCS_RST_TIME;
		end else begin
			s <= n;
		end
	end

	assign avs_readdata = s.rdata;
	assign avs_waitrequest = req && !s.ack;
	assign digital_out = s.mask; // R6
	assign speed_hold = s.spd_hold;
	assign speed_target = s.speed;
	assign tech_ctrl_hold = s.tech_hold;
endmodule
`default_nettype wire

// ---- verif/pcs_stager_asserts.sv ----
// Purpose: Port-level checks of the cascade stager.
// Assumes: Bound to pcs_stager; one clock domain.
// Notes: Delay and hold lengths depend on registers and are measured by the bench.
`include "pcs_cfg.svh"
`default_nettype none
module pcs_stager_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic main_at_switch_speed,
	input wire logic [2:0] digital_out,
	input wire logic speed_hold,
	input wire logic [15:0] speed_target,
	input wire logic tech_ctrl_hold
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_ramp_entry;
		$rose(tech_ctrl_hold) ##0 $rose(speed_hold);
	endsequence
	sequence s_ramp_exit;
		!tech_ctrl_hold && speed_hold;
	endsequence
	property p_one_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_idle_bus;
		!(avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	property p_ramp_on_switch;
		$rose(tech_ctrl_hold) |-> s_ramp_entry ##0 $changed(digital_out);
	endproperty
	property p_ctrl_off_in_ramp;
		tech_ctrl_hold |-> speed_hold;
	endproperty
	property p_ramp_waits;
		tech_ctrl_hold && !main_at_switch_speed |=> tech_ctrl_hold;
	endproperty
	property p_ramp_ends;
		tech_ctrl_hold && main_at_switch_speed |=> s_ramp_exit;
	endproperty
	property p_out_stable_in_hold;
		speed_hold && $past(speed_hold) |-> $stable(digital_out);
	endproperty
	property p_target_written;
		$changed(speed_target) |-> $past(avs_write) && $past(avs_address) == `PCS_ADR_SPEED;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait state not one cycle");
	a_idle_bus: assert property (p_idle_bus) else $error("wait without request");
	a_ramp_on_switch: assert property (p_ramp_on_switch) else $error("ramp without switch");
	a_ctrl_off_in_ramp: assert property (p_ctrl_off_in_ramp) else $error("hold missing");
	a_ramp_waits: assert property (p_ramp_waits) else $error("ramp left early");
	a_ramp_ends: assert property (p_ramp_ends) else $error("no hold after ramp");
	a_out_stable_in_hold: assert property (p_out_stable_in_hold) else $error("switch in hold");
	a_target_written: assert property (p_target_written) else $error("target moved");
endmodule
bind pcs_stager pcs_stager_asserts pcs_stager_asserts_i (.clk_sys, .rst_n, .avs_address,
	.avs_read, .avs_write, .avs_waitrequest, .main_at_switch_speed, .digital_out,
	.speed_hold, .speed_target, .tech_ctrl_hold);
`default_nettype wire

// ---- verif/pcs_drive_model.sv ----
// Purpose: Contactors and main drive seen from the stager.
// Assumes: The drive needs RAMP_CYC cycles to reach the switch speed.
// Notes: Switch speed is reported from RAMP_CYC cycles into a controller hold until one cycle after the hold ends.
`default_nettype none
module pcs_drive_model #(
	parameter int RAMP_CYC = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tech_ctrl_hold,
	input wire logic [2:0] digital_out,
	output logic main_at_switch_speed,
	output logic [2:0] motor_running
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_q;
	// Contactors pull in one cycle late so the mask seen by the motors lags the command.
	always_ff @(posedge clk_sys) begin
		motor_running <= rst_n ? digital_out : 3'h0;
		cnt_q <= (rst_n && tech_ctrl_hold) ? cnt_q + 4'h1 : 4'h0;
	end
	assign main_at_switch_speed = cnt_q >= 4'(RAMP_CYC);
endmodule
`default_nettype wire

// ---- verif/test_pump_cascade_stager.sv ----
// Purpose: Self-checking bench for the cascade stager.
// Assumes: TICK_CYC of 4, so one millisecond tick is four cycles.
// Notes: Expected masks come from the stage tables held below.
`default_nettype none
module test_pump_cascade_stager;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n, avs_read, avs_write, avs_waitrequest, main_at_max, main_at_min;
	logic main_at_switch_speed, staging_enable_pin, off_command_pin, speed_hold, tech_ctrl_hold;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic signed [15:0] pid_deviation;
	logic [15:0] speed_target;
	logic [2:0] digital_out;
	int errors = 0;
	int total_checks = 0;
	int n, h, lv;
	localparam logic [17:0] SEQ [9] = '{18'h00000, 18'h00001, 18'h00019, 18'h000D1,
		18'h001D9, 18'h00F61, 18'h07CD1, 18'h07B19, 18'h3EB11};
	localparam logic [2:0] HRS [6] = '{3'h2, 3'h6, 3'h7, 3'h6, 3'h2, 3'h0};
	pcs_stager #(.TICK_CYC(4)) pcs_stager_i (.clk_sys, .rst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.pid_deviation, .main_at_max, .main_at_min, .main_at_switch_speed,
		.staging_enable_pin, .off_command_pin, .digital_out, .speed_hold, .speed_target,
		.tech_ctrl_hold);
	pcs_drive_model pcs_drive_model_i (.clk_sys, .rst_n, .tech_ctrl_hold, .digital_out,
		.main_at_switch_speed, .motor_running());
	always #2.5 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h", $time, m, got);
			errors++;
		end
	endtask
	task automatic ok(input logic c, input string m);
		chk({31'h0, c}, 32'h1, m);
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		ok(k < 20, "bus timeout");
		if (k >= 20) begin
			end_of_test();
		end
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk(q, e, "read data");
	endtask
	// A refused request runs the full window; a taken one stops waiting when the mask moves, then waits out the hold.
	task automatic step(input logic signed [15:0] dev, input logic [2:0] exp,
		output int sn, output int sh);
		logic [2:0] prev;
		prev = digital_out;
		sn = 0;
		sh = 0;
		pid_deviation <= dev;
		main_at_max <= dev > 0;
		main_at_min <= dev < 0;
		while (digital_out === prev && sn < 200) begin
			@(posedge clk_sys);
			sn++;
		end
		pid_deviation <= 16'sh0000;
		main_at_max <= 1'b0;
		main_at_min <= 1'b0;
		while (speed_hold !== 1'b0 && sh < 200) begin
			@(posedge clk_sys);
			sh++;
		end
		// A hold that never ends would stall every later step, so stop here.
		if (sh >= 200) begin
			ok(1'b0, "hold timeout");
			end_of_test();
		end
		chk({29'h0, digital_out}, {29'h0, exp}, "motor mask");
		@(posedge clk_sys);
	endtask
	initial begin
		rst_n = 1'b0;
		{avs_read, avs_write, main_at_max, main_at_min} = 4'h0;
		{staging_enable_pin, off_command_pin} = 2'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		pid_deviation = 16'sh0000;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		for (int a = 0; a < 32; a++)
			rd(5'(a), a == 1 ? 32'h00000100 : a == 2 ? 32'h00000400 : a == 6 ? 32'h00004000 : 32'h0);
		wr(5'h07, 16'hFFFF);
		rd(5'h07, 32'h00000000);
		avs_byteenable <= 4'h1;
		wr(5'h01, 16'h0055);
		avs_byteenable <= 4'hF;
		rd(5'h01, 32'h00000100);
		wr(5'h06, 16'h1234);
		chk({16'h0, speed_target}, 32'h00001234, "target");
		for (int c = 0; c < 9; c++) begin
			wr(5'h00, 16'h0140 | 16'(c));
			lv = 0;
			while (lv < 6 && SEQ[c][3*lv+:3] != 3'h0) begin
				step(16'sh2000, SEQ[c][3*lv+:3], n, h);
				lv++;
			end
			step(16'sh2000, lv == 0 ? 3'h0 : SEQ[c][3*lv-3+:3], n, h);
			while (lv > 0) begin
				lv--;
				step(-16'sh2000, lv == 0 ? 3'h0 : SEQ[c][3*lv-3+:3], n, h);
			end
		end
		wr(5'h00, 16'h0141);
		wr(5'h03, 16'h0005);
		wr(5'h04, 16'h0005);
		wr(5'h08, 16'h0002);
		wr(5'h0A, 16'h0002);
		wr(5'h09, 16'h0003);
		wr(5'h0B, 16'h0008);
		step(16'sh0200, 3'h1, n, h);
		ok(n >= 24 && h >= 8 && h < 28, "slow add");
		step(-16'sh0200, 3'h0, n, h);
		ok(n >= 24 && h >= 28, "slow remove");
		step(16'sh2000, 3'h1, n, h);
		ok(n >= 4 && n < 20, "fast add");
		step(-16'sh2000, 3'h0, n, h);
		ok(n >= 4 && n < 20, "fast remove");
		// The add loads sixteen ticks of interlock; the remove must wait them out.
		wr(5'h05, 16'h0010);
		step(16'sh2000, 3'h1, n, h);
		step(-16'sh2000, 3'h0, n, h);
		ok(n >= 40 && n < 100, "interlock");
		for (int a = 3; a < 12; a++)
			wr(5'(a), 16'h0000);
		wr(5'h00, 16'h0041);
		step(16'sh2000, 3'h0, n, h);
		wr(5'h00, 16'h0341);
		step(16'sh2000, 3'h0, n, h);
		wr(5'h00, 16'h05C4);
		step(16'sh2000, 3'h0, n, h);
		staging_enable_pin <= 1'b1;
		for (int k = 0; k < 3; k++)
			step(16'sh2000, SEQ[4][3*k+:3], n, h);
		off_command_pin <= 1'b1;
		step(16'sh0000, 3'h0, n, h);
		off_command_pin <= 1'b0;
		wr(5'h00, 16'h0158);
		wr(5'h0E, 16'h000A);
		wr(5'h0F, 16'h0000);
		wr(5'h10, 16'h0005);
		rd(5'h0E, 32'h0000000A);
		for (int k = 0; k < 6; k++)
			step(k < 3 ? 16'sh2000 : -16'sh2000, HRS[k], n, h);
		// Motor one is past the absolute limit, so only two motors can be added.
		wr(5'h0D, 16'h0008);
		for (int k = 0; k < 3; k++)
			step(16'sh2000, k == 0 ? 3'h2 : 3'h6, n, h);
		// Pushing a running motor past the limit forces it off without demand.
		wr(5'h0F, 16'h0010);
		step(16'sh0000, 3'h4, n, h);
		wr(5'h0D, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
